// >>> dv/low_power_port_clock_gating_test.sv
// testbench: apb registers, mode selection and port faults of the gate block
module low_power_port_clock_gating_test
   import pcg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rnd = 32'h200d_d19f;
   logic pready, pslverr, slp = 0, dsl = 0, go = 0, a_req, fault, ok;
   logic [1:0] idx = 0, a_idx;
   logic [2:0] en, mode;
   logic [32:0] bus_q[$];
   logic [1:0] acc_q[$];
   int errors = 0, tests_run = 0;
   always #2 clock = ~clock;
   pcg_top i_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_req(slp), .deep_sleep_req(dsl), .port_acc_req(a_req),
      .port_acc_idx(a_idx), .port_clk_en(en), .power_mode(mode),
      .port_bus_fault(fault), .port_acc_ok(ok));
   pcg_port_model i_port (.clock(clock), .rst_b(rst_b), .go(go),
      .idx(idx), .acc_req(a_req), .acc_idx(a_idx));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d, comparisons %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one apb transfer; the expected answer is noted before it starts
   task automatic apb(input logic w, input logic [11:0] off,
                      input logic [31:0] d, input logic [32:0] e);
      bus_q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= SYSCTL_BASE + {20'h0_0000, off};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      // pready ends this wait; the watchdog only catches a hang
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic mode_chk(input logic s, input logic ds,
                           input logic [2:0] m, input logic [2:0] e);
      slp <= s;
      dsl <= ds;
      repeat (2) @(posedge clock);
      #1;
      chk({27'h0, mode, en}, {27'h0, m, e});
      @(posedge clock);
   endtask
   // access every port once; a clear enable must end in a fault
   task automatic ports(input logic [2:0] e);
      for (int i = 0; i < 4; i++) begin
         acc_q.push_back((i < 3 && e[i]) ? 2'b01 : 2'b10);
         go <= 1'b1;
         idx <= i[1:0];
         @(posedge clock);
         go <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && bus_q.size() > 0) begin
         chk({pslverr, pwrite ? 32'h0 : prdata},
             bus_q.pop_front());
      end
      if ((fault | ok) === 1'b1 && acc_q.size() > 0) begin
         chk({31'h0, fault, ok},
             {31'h0, acc_q.pop_front()});
      end
   end
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      apb(0, RUN_GATE_OFF, 0, 33'h0);
      apb(0, SLEEP_GATE_OFF, 0, 33'h0);
      apb(0, DEEP_GATE_OFF, 0, 33'h0);
      apb(0, RUN_CFG_OFF, 0, 33'h0);
      apb(0, 12'h11c, 0, {1'b1, 32'h0});
      apb(1, 12'h11c, 32'hffff_ffff, {1'b1, 32'h0});
      apb(1, SLEEP_GATE_OFF, 32'hffff_ffff, 33'h0);
      apb(0, SLEEP_GATE_OFF, 0, 33'h0_0000_0007);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         apb(1, DEEP_GATE_OFF, rnd, 33'h0);
         apb(0, DEEP_GATE_OFF, 0, {30'h0, rnd[2:0]});
      end
      // software enables the ports it needs before touching them
      apb(1, RUN_GATE_OFF, 32'h0000_0001, 33'h0);
      apb(1, SLEEP_GATE_OFF, 32'hffff_fffa, 33'h0);
      apb(1, DEEP_GATE_OFF, 32'h0000_0006, 33'h0);
      mode_chk(1, 0, MODE_RUN, 3'b001);
      ports(3'b001);
      apb(1, RUN_CFG_OFF, 32'hffff_ffff, 33'h0);
      apb(0, RUN_CFG_OFF, 0, 33'h0_0000_0001);
      mode_chk(1, 0, MODE_SLEEP, 3'b010);
      ports(3'b010);
      mode_chk(1, 1, MODE_DEEP, 3'b110);
      ports(3'b110);
      mode_chk(0, 0, MODE_RUN, 3'b001);
      // a second reset in mid-run must clear every gating register
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      apb(0, SLEEP_GATE_OFF, 0, 33'h0);
      apb(0, DEEP_GATE_OFF, 0, 33'h0);
      mode_chk(0, 0, MODE_RUN, 3'b000);
      repeat (4) @(posedge clock);
      // every noted answer must have come back
      chk(33'(acc_q.size() + bus_q.size()), 33'h0);
      complete_run();
   end
endmodule

// >>> dv/pcg_port_model.sv
// partner model: port traffic issued by the bus fabric toward gated ports
module pcg_port_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // command from the bench
   input wire logic go,
   input wire logic [1:0] idx,
   // access toward the gating block
   output logic acc_req,
   output logic [1:0] acc_idx
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         acc_req <= 1'b0;
         acc_idx <= 2'h0;
      end else begin
         acc_req <= go;
         // an idle index keeps moving so it never looks like a request
         acc_idx <= go ? idx : ~acc_idx;
      end
   end
endmodule

// >>> logic/pcg_fault_check.sv
// module: checks each port access against the port's current clock enable
module pcg_fault_check
   import pcg_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // access request and port clock enables
   input wire logic acc_req,
   input wire logic [1:0] acc_idx,
   input wire logic [NPORT-1:0] clk_en,
   // result
   output logic fault_reg,
   output logic ok_reg
);

   logic clocked;

   //////////////////////////////////////////////////////////////////////////
   // an index past the last port counts as unclocked
   always_comb begin
      clocked = 1'b0;
      if (32'(acc_idx) < NPORT) begin
         clocked = clk_en[acc_idx];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fault_reg <= 1'b0;
         ok_reg <= 1'b0;
      end else begin
         fault_reg <= acc_req && !clocked;
         ok_reg <= acc_req && clocked;
      end
   end

endmodule

// >>> logic/pcg_gate_reg.sv
// module: software register holding only its implemented low bits
module pcg_gate_reg
   import pcg_pkg::*;
#(
   parameter int W = NPORT,
   parameter logic [31:0] RESET_VAL = GATE_RESET
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // write port
   input wire logic wr_en,
   input wire logic [31:0] wdata,
   // stored value
   output logic [W-1:0] value_reg
);

   //////////////////////////////////////////////////////////////////////////
   // upper write data is dropped so the unused bits stay zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         value_reg <= RESET_VAL[W-1:0];
      end else if (wr_en) begin
         value_reg <= wdata[W-1:0];
      end
   end

endmodule

// >>> logic/pcg_pkg.sv
// package: address map, field layout and modes of the port clock gating block
package pcg_pkg;

   // number of gated ports
   localparam int NPORT = 3;

   // address map
   localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;
   localparam logic [11:0] RUN_GATE_OFF = 12'h108;
   localparam logic [11:0] SLEEP_GATE_OFF = 12'h118;
   localparam logic [11:0] DEEP_GATE_OFF = 12'h128;
   localparam logic [11:0] RUN_CFG_OFF = 12'h200;

   // gating register bank index
   localparam logic [1:0] BANK_RUN = 2'h0;
   localparam logic [1:0] BANK_SLEEP = 2'h1;
   localparam logic [1:0] BANK_DEEP = 2'h2;
   localparam int NBANK = 3;

   // field positions
   localparam int FIRST_PORT_CLOCK_ENABLE = 0;
   localparam int SECOND_PORT_CLOCK_ENABLE = 1;
   localparam int THIRD_PORT_CLOCK_ENABLE = 2;
   localparam int AUTOMATIC_GATING_SELECT = 0;
   localparam int CFG_W = 1;

   // reset values
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // power mode, one-hot
   typedef enum logic [2:0] {
      MODE_RUN = 3'h1,
      MODE_SLEEP = 3'h2,
      MODE_DEEP = 3'h4
   } pcg_mode_t;

endpackage

// >>> logic/pcg_top.sv
// module: port clock gating for run, sleep and deep-sleep with apb registers
module pcg_top
   import pcg_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power mode requests from the core
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   // port access from the bus fabric
   input wire logic port_acc_req,
   input wire logic [1:0] port_acc_idx,
   // port clock enables and status
   output logic [NPORT-1:0] port_clk_en,
   output logic [2:0] power_mode,
   output logic port_bus_fault,
   output logic port_acc_ok
);

   //////////////////////////////////////////////////////////////////////////
   // address decode helpers

   function automatic logic addr_hit(input logic [31:0] addr,
                                     input logic [11:0] off);
      addr_hit = (addr == (SYSCTL_BASE + {20'h0_0000, off}));
   endfunction

   function automatic logic [11:0] bank_off(input int bank);
      logic [11:0] off;
      off = RUN_GATE_OFF;
      if (bank == int'(BANK_SLEEP)) begin
         off = SLEEP_GATE_OFF;
      end else if (bank == int'(BANK_DEEP)) begin
         off = DEEP_GATE_OFF;
      end
      return off;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait-free access phase, answer registered at setup

   logic setup;
   logic access;
   logic wr_take;
   logic [NBANK-1:0] gate_wr;
   logic cfg_wr;
   logic [NPORT-1:0] gate_val [NBANK];
   logic [CFG_W-1:0] cfg_val;
   logic [31:0] rdata_next;
   logic mapped_next;

   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_take = access && pwrite;

   always_comb begin
      rdata_next = READ_ZERO;
      mapped_next = 1'b1;
      if (addr_hit(paddr, RUN_GATE_OFF)) begin
         rdata_next[NPORT-1:0] = gate_val[BANK_RUN];
      end else if (addr_hit(paddr, SLEEP_GATE_OFF)) begin
         rdata_next[NPORT-1:0] = gate_val[BANK_SLEEP];
      end else if (addr_hit(paddr, DEEP_GATE_OFF)) begin
         rdata_next[NPORT-1:0] = gate_val[BANK_DEEP];
      end else if (addr_hit(paddr, RUN_CFG_OFF)) begin
         rdata_next[CFG_W-1:0] = cfg_val;
      end else begin
         mapped_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // unused bits above the port enables stay zero in the read word
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= READ_ZERO;
      end else if (setup && !pwrite) begin
         prdata <= rdata_next;
      end else if (access) begin
         prdata <= READ_ZERO;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !mapped_next;
      end else begin
         pslverr <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // gating registers: run, sleep, deep-sleep

   genvar gi;
   generate
      for (gi = 0; gi < NBANK; gi++) begin : g_bank
         assign gate_wr[gi] = wr_take && addr_hit(paddr, bank_off(gi));
         pcg_gate_reg #(
            .W(NPORT),
            .RESET_VAL(GATE_RESET)
         ) u_gate (
            .clock(clock),
            .rst_b(rst_b),
            .wr_en(gate_wr[gi]),
            .wdata(pwdata),
            .value_reg(gate_val[gi])
         );
      end
   endgenerate

   assign cfg_wr = wr_take && addr_hit(paddr, RUN_CFG_OFF);

   pcg_gate_reg #(
      .W(CFG_W),
      .RESET_VAL(CFG_RESET)
   ) u_cfg (
      .clock(clock),
      .rst_b(rst_b),
      .wr_en(cfg_wr),
      .wdata(pwdata),
      .value_reg(cfg_val)
   );

   //////////////////////////////////////////////////////////////////////////
   // power mode selection

   logic automatic_gating_select;
   pcg_mode_t mode_reg;
   pcg_mode_t mode_next;
   logic [NPORT-1:0] clk_en_next;

   assign automatic_gating_select = cfg_val[AUTOMATIC_GATING_SELECT];

   // deep-sleep outranks sleep when both are requested
   always_comb begin
      mode_next = MODE_RUN;
      if (automatic_gating_select && deep_sleep_req) begin
         mode_next = MODE_DEEP;
      end else if (automatic_gating_select && sleep_req) begin
         mode_next = MODE_SLEEP;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mode_reg <= MODE_RUN;
      end else begin
         mode_reg <= mode_next;
      end
   end

   always_comb begin
      case (mode_next)
         MODE_SLEEP: begin
            clk_en_next = gate_val[BANK_SLEEP];
         end
         MODE_DEEP: begin
            clk_en_next = gate_val[BANK_DEEP];
         end
         default: begin
            clk_en_next = gate_val[BANK_RUN];
         end
      endcase
   end

   // enables leave one flop only, so the external gate cell sees a clean
   // level that changes once per cycle and never mid-pulse
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         port_clk_en <= GATE_RESET[NPORT-1:0];
      end else begin
         port_clk_en <= clk_en_next;
      end
   end

   assign power_mode = mode_reg;

   //////////////////////////////////////////////////////////////////////////
   // bus fault on access to a gated port

   pcg_fault_check u_fault (
      .clock(clock),
      .rst_b(rst_b),
      .acc_req(port_acc_req),
      .acc_idx(port_acc_idx),
      .clk_en(port_clk_en),
      .fault_reg(port_bus_fault),
      .ok_reg(port_acc_ok)
   );

   //////////////////////////////////////////////////////////////////////////
   // assertions

   logic [NPORT-1:0] run_gate;
   logic [NPORT-1:0] sleep_gate;
   logic [NPORT-1:0] deep_gate;
   logic idx_in_range;
   logic gate_wr_any;

   assign run_gate = gate_val[BANK_RUN];
   assign sleep_gate = gate_val[BANK_SLEEP];
   assign deep_gate = gate_val[BANK_DEEP];
   assign idx_in_range = 32'(port_acc_idx) < NPORT;
   // a register write reaches the enables two edges later
   assign gate_wr_any = |gate_wr;

   a_sleep_select: assert property (
      @(posedge clock) disable iff (!rst_b)
      automatic_gating_select && sleep_req && !deep_sleep_req
      |=> port_clk_en == $past(sleep_gate) && mode_reg == MODE_SLEEP
   ) else $error("sleep mode did not use the sleep gating register");

   a_deep_select: assert property (
      @(posedge clock) disable iff (!rst_b)
      automatic_gating_select && deep_sleep_req
      |=> port_clk_en == $past(deep_gate) && mode_reg == MODE_DEEP
   ) else $error("deep-sleep mode did not use the deep gating register");

   a_acg_gates: assert property (
      @(posedge clock) disable iff (!rst_b)
      !automatic_gating_select |=> mode_reg == MODE_RUN && port_clk_en == $past(run_gate)
   ) else $error("sleep gating applied without automatic gating select");

   a_fault_gated: assert property (
      @(posedge clock) disable iff (!rst_b)
      port_acc_req && (!idx_in_range || !port_clk_en[port_acc_idx])
      |=> port_bus_fault && !port_acc_ok
   ) else $error("access to an unclocked port gave no bus fault");

   a_clocked_ok: assert property (
      @(posedge clock) disable iff (!rst_b)
      port_acc_req && idx_in_range && port_clk_en[port_acc_idx]
      |=> port_acc_ok && !port_bus_fault
   ) else $error("access to a clocked port was faulted");

   a_gated_off: assert property (
      @(posedge clock) disable iff (!rst_b)
      mode_next == MODE_DEEP
      |=> (port_clk_en & ~$past(deep_gate)) == GATE_RESET[NPORT-1:0]
   ) else $error("clock left running for a port gated off");

   a_reset_zero: assert property (
      @(posedge clock)
      !rst_b |=> sleep_gate == GATE_RESET[NPORT-1:0]
         && deep_gate == GATE_RESET[NPORT-1:0]
   ) else $error("gating registers not zero after reset");

   a_sleep_write: assert property (
      @(posedge clock) disable iff (!rst_b)
      wr_take && addr_hit(paddr, SLEEP_GATE_OFF)
      |=> sleep_gate == $past(pwdata[NPORT-1:0])
   ) else $error("sleep gating register write not stored");

   a_deep_write: assert property (
      @(posedge clock) disable iff (!rst_b)
      wr_take && addr_hit(paddr, DEEP_GATE_OFF)
      |=> deep_gate == $past(pwdata[NPORT-1:0])
   ) else $error("deep gating register write not stored");

   a_reserved_zero: assert property (
      @(posedge clock) disable iff (!rst_b)
      access && !pwrite |-> prdata[31:NPORT] == READ_ZERO[31:NPORT]
   ) else $error("reserved gating bits read nonzero");

   a_run_select: assert property (
      @(posedge clock) disable iff (!rst_b)
      mode_next == MODE_RUN |=> port_clk_en == $past(run_gate)
   ) else $error("run mode did not use the run gating register");

   a_clean_switch: assert property (
      @(posedge clock) disable iff (!rst_b)
      $changed(port_clk_en) |-> $changed(mode_reg)
         || $past(gate_wr_any, 2)
   ) else $error("clock enable moved without mode change or write");

endmodule
